// ===== inc/aodc_params.svh
`ifndef AODC_PARAMS_SVH
`define AODC_PARAMS_SVH
`define AODC_CLK_MHZ 100
`define AODC_STEP_BASE_US 1000
`define AODC_STEP_BASE_CYCLES (`AODC_STEP_BASE_US * `AODC_CLK_MHZ)
`define AODC_REG_BYPASS_L 8'h00
`define AODC_REG_BYPASS_R 8'h01
`define AODC_REG_EAR_CONF 8'h02
`define AODC_REG_HS_EN 8'h03
`define AODC_REG_HS_GAIN 8'h04
`define AODC_REG_HS_CONF 8'h05
`define AODC_REG_SHORT_CONF 8'h06
`define AODC_REG_PUMP_CONF 8'h07
`define AODC_REG_ENV_THRESH 8'h08
`define AODC_REG_ENV_TIME 8'h09
`define AODC_REG_IRQ 8'h0A
`define AODC_REG_STATUS 8'h0B
`define AODC_REG_HS_CUR_GAIN 8'h0C
`define AODC_IRQ_EAR 0
`define AODC_IRQ_HSL 1
`define AODC_IRQ_HSR 2
`define AODC_RST_BYTE 8'h00
`define AODC_HS_GAIN_MIN 4'h0
`define AODC_BYPASS_MAX 5'h12
`define AODC_MAX_CHANNELS 3'h6
`endif

// ===== inc/aodc_pkg.sv
`default_nettype none
package aodc_pkg;
  typedef logic [3:0] aodc_gain_t;
  typedef enum logic [1:0] {AODC_SUP_LOW, AODC_SUP_BATT} aodc_supply_e;
  // headset code to dB: 4 dB steps up to -20, then 2 dB steps
  function automatic logic signed [7:0] aodc_hs_gain_db(input aodc_gain_t c);
    if (c < 4'h4) return 8'(-32 + 4 * int'(c));
    return 8'(-20 + 2 * (int'(c) - 3));
  endfunction
  function automatic logic [4:0] aodc_bypass_clamp(input logic [4:0] c);
    return (c > 5'h12) ? 5'h12 : c;
  endfunction
endpackage
`default_nettype wire

// ===== logic/aodc_env_det.sv
`timescale 1ns/10ps
`default_nettype none
module aodc_env_det (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic manual_low_in,
  input wire logic [3:0] level_in,
  input wire logic [3:0] high_thresh_in,
  input wire logic [3:0] low_thresh_in,
  input wire logic [3:0] decay_in,
  input wire logic tick_in,
  output logic battery_sel_out
);
  logic [3:0] decay_cnt;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      battery_sel_out <= 1'b1;
      decay_cnt <= 4'h0;
    end else if (!enable_in) begin
      battery_sel_out <= ~manual_low_in;
      decay_cnt <= 4'h0;
    end else if (level_in > high_thresh_in) begin
      battery_sel_out <= 1'b1;
      decay_cnt <= 4'h0;
    end else if (battery_sel_out && level_in < low_thresh_in) begin
      if (decay_cnt >= decay_in) begin
        battery_sel_out <= 1'b0;
        decay_cnt <= 4'h0;
      end else if (tick_in) begin
        decay_cnt <= decay_cnt + 4'h1;
      end
    end else begin
      decay_cnt <= 4'h0;
    end
  end
  AST_ENV_HIGH: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enable_in && level_in > high_thresh_in |=> battery_sel_out)
    else $error("supply not switched to battery on high level");
  AST_ENV_HOLD: assert property (@(posedge core_clk_in) disable iff (reset_in)
    enable_in && battery_sel_out && level_in >= low_thresh_in |=> battery_sel_out)
    else $error("left battery supply above low threshold");
  AST_ENV_MANUAL: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !enable_in |=> battery_sel_out == !$past(manual_low_in))
    else $error("manual supply select ignored");
endmodule
`default_nettype wire

// ===== logic/aodc_hs_ramp.sv
`timescale 1ns/10ps
`default_nettype none
`include "aodc_params.svh"
module aodc_hs_ramp (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic mute_in,
  input wire logic [3:0] target_gain_in,
  input wire logic step_tick_in,
  input wire logic zero_cross_in,
  input wire logic [1:0] speed_in,
  input wire logic ramp_disable_in,
  input wire logic zc_disable_in,
  output logic [3:0] gain_out,
  output logic powered_out,
  output logic mute_out
);
  logic req, step, due, force_step;
  logic [3:0] goal, timer, win;
  assign req = enable_in & ~mute_in;
  assign goal = req ? target_gain_in : `AODC_HS_GAIN_MIN;
  assign win = {2'b00, speed_in} + 4'h1;
  assign due = timer >= win;
  // a missing zero cross must not freeze the ramp forever
  assign force_step = timer >= {win[2:0], 1'b0};
  assign step = (gain_out != goal) &
    ((due & (zero_cross_in | zc_disable_in)) | force_step);
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      gain_out <= `AODC_HS_GAIN_MIN;
    end else if (ramp_disable_in) begin
      gain_out <= goal;
    end else if (step) begin
      gain_out <= (gain_out < goal) ? gain_out + 4'h1 : gain_out - 4'h1;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (reset_in || step || gain_out == goal) begin
      timer <= 4'h0;
    end else if (step_tick_in && timer != 4'h8) begin
      timer <= timer + 4'h1;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      powered_out <= 1'b0;
      mute_out <= 1'b1;
    end else begin
      powered_out <= enable_in | (powered_out & gain_out != goal);
      mute_out <= ~powered_out | (~req & gain_out == goal);
    end
  end
  AST_ONE_STEP: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !ramp_disable_in |=> ($past(gain_out) - gain_out == 4'h1) ||
      (gain_out - $past(gain_out) == 4'h1) || gain_out == $past(gain_out))
    else $error("gain moved more than one code");
  AST_IMMEDIATE: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ramp_disable_in |=> gain_out == $past(goal))
    else $error("ramp bypass did not apply gain at once");
  sequence s_off_req;
    powered_out && !enable_in && gain_out != `AODC_HS_GAIN_MIN;
  endsequence
  AST_DOWN_FIRST: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_off_req |=> powered_out)
    else $error("driver powered down before ramp reached minimum");
  AST_START_MUTED: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !powered_out ##1 powered_out |-> mute_out)
    else $error("driver did not start muted");
endmodule
`default_nettype wire

// ===== logic/aodc_top.sv
// Contract
// - bypass attenuation -36..0 dB, 2 dB steps
// - earpiece enables, mute and low-power selects
// - one bit picks earpiece DAC source
// - earpiece short protection on; sets flag
// - headset short protection per side flags
// - auto power-down bit disables shorted driver
// - separate short disable for earpiece, headset
// - headset starts muted, ramps up gain
// - step duration by speed, zero cross
// - headset gain code to dB mapping
// - gain changes walk every intermediate code
// - separate ramp and zero-cross disable bits
// - mute or disable ramps down first
// - high-pass and headset low-power selects
// - disabled headset hi-z or pulled down
// - pump enable; headset may follow it
// - above high threshold: battery supply at once
// - below low for decay time: low supply
// - earpiece common-mode two-bit select
// - at most six channels active; code only raises channel_overload_out above six, nothing is turned off
// - manual supply select when detector off
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "aodc_params.svh"
module aodc_top #(
  parameter int STEP_BASE_CYCLES = `AODC_STEP_BASE_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  input wire logic ear_short_in,
  input wire logic hs_short_left_in,
  input wire logic hs_short_right_in,
  input wire logic zero_cross_left_in,
  input wire logic zero_cross_right_in,
  input wire logic [3:0] envelope_level_in,
  input wire logic [2:0] other_channels_in,
  output logic [4:0] bypass_gain_left_out,
  output logic [4:0] bypass_gain_right_out,
  output logic hs_stage_en_left_out,
  output logic hs_stage_en_right_out,
  output logic earpiece_drv_on_out,
  output logic earpiece_dac_on_out,
  output logic earpiece_mute_out,
  output logic earpiece_drv_lowpower_out,
  output logic earpiece_dac_lowpower_out,
  output logic earpiece_source_sel_out,
  output logic [1:0] earpiece_common_mode_sel_out,
  output logic [3:0] hs_gain_left_out,
  output logic [3:0] hs_gain_right_out,
  output logic signed [7:0] hs_gain_db_left_out,
  output logic signed [7:0] hs_gain_db_right_out,
  output logic hs_drv_on_left_out,
  output logic hs_drv_on_right_out,
  output logic hs_mute_left_out,
  output logic hs_mute_right_out,
  output logic hs_dac_on_left_out,
  output logic hs_dac_on_right_out,
  output logic hs_highpass_enable_out,
  output logic hs_drv_lowpower_out,
  output logic [1:0] hs_dac_lowpower_out,
  output logic hs_pulldown_out,
  output logic neg_pump_run_out,
  output logic pump_battery_sel_out,
  output logic channel_overload_out
);
  if (STEP_BASE_CYCLES < 2) begin : g_chk
    $error("STEP_BASE_CYCLES must be at least 2");
  end

  logic [4:0] bypass_gain_left, bypass_gain_right;
  logic [7:0] ear_conf, hs_en, hs_gain, hs_conf, short_conf, pump_conf;
  logic [7:0] env_thresh;
  logic [3:0] env_time;
  logic [2:0] irq_flags;
  logic ear_trip, hsl_trip, hsr_trip;
  logic [4:0] sync_a, sync_b;
  logic ear_short, hsl_short, hsr_short, zc_left, zc_right;
  logic ear_det, hsl_det, hsr_det;
  logic [2:0] det_vec;
  logic ear_drv_on, hsl_en_eff, hsr_en_eff;
  logic wr_irq, rd_irq;
  logic [31:0] div_cnt;
  logic step_tick;
  logic [3:0] cur_left, cur_right;
  logic hsl_powered, hsr_powered;
  logic [2:0] own_channels;

  wire earpiece_enable = ear_conf[0];
  wire earpiece_dac_enable = ear_conf[1];
  wire auto_pd = short_conf[0];
  wire earpiece_short_disable = short_conf[1];
  wire hs_short_disable = short_conf[2];
  wire neg_pump_enable = pump_conf[0];
  wire hs_follow_pump_enable = pump_conf[1];

  // analog comparator pins are asynchronous to the core clock
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {zero_cross_right_in, zero_cross_left_in, hs_short_right_in,
        hs_short_left_in, ear_short_in};
      sync_b <= sync_a;
    end
  end
  assign {zc_right, zc_left, hsr_short, hsl_short, ear_short} = sync_b;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      bypass_gain_left <= 5'h00;
      bypass_gain_right <= 5'h00;
      ear_conf <= `AODC_RST_BYTE;
      hs_en <= `AODC_RST_BYTE;
      hs_gain <= `AODC_RST_BYTE;
      hs_conf <= `AODC_RST_BYTE;
      short_conf <= `AODC_RST_BYTE;
      pump_conf <= `AODC_RST_BYTE;
      env_thresh <= `AODC_RST_BYTE;
      env_time <= 4'h0;
    end else if (reg_write_in) begin
      unique case (reg_addr_in)
        `AODC_REG_BYPASS_L: bypass_gain_left <= reg_wdata_in[4:0];
        `AODC_REG_BYPASS_R: bypass_gain_right <= reg_wdata_in[4:0];
        `AODC_REG_EAR_CONF: ear_conf <= reg_wdata_in;
        `AODC_REG_HS_EN: hs_en <= reg_wdata_in;
        `AODC_REG_HS_GAIN: hs_gain <= reg_wdata_in;
        `AODC_REG_HS_CONF: hs_conf <= reg_wdata_in;
        `AODC_REG_SHORT_CONF: short_conf <= {4'h0, reg_wdata_in[3:0]};
        `AODC_REG_PUMP_CONF: pump_conf <= {4'h0, reg_wdata_in[3:0]};
        `AODC_REG_ENV_THRESH: env_thresh <= reg_wdata_in;
        `AODC_REG_ENV_TIME: env_time <= reg_wdata_in[3:0];
        default: ;
      endcase
    end
  end

  assign wr_irq = reg_write_in && reg_addr_in == `AODC_REG_IRQ;
  assign rd_irq = reg_read_in && reg_addr_in == `AODC_REG_IRQ;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        `AODC_REG_BYPASS_L: reg_rdata_out <= {3'h0, bypass_gain_left};
        `AODC_REG_BYPASS_R: reg_rdata_out <= {3'h0, bypass_gain_right};
        `AODC_REG_EAR_CONF: reg_rdata_out <= ear_conf;
        `AODC_REG_HS_EN: reg_rdata_out <= hs_en;
        `AODC_REG_HS_GAIN: reg_rdata_out <= hs_gain;
        `AODC_REG_HS_CONF: reg_rdata_out <= hs_conf;
        `AODC_REG_SHORT_CONF: reg_rdata_out <= short_conf;
        `AODC_REG_PUMP_CONF: reg_rdata_out <= pump_conf;
        `AODC_REG_ENV_THRESH: reg_rdata_out <= env_thresh;
        `AODC_REG_ENV_TIME: reg_rdata_out <= {4'h0, env_time};
        `AODC_REG_IRQ: reg_rdata_out <= {5'h00, irq_flags};
        `AODC_REG_STATUS: reg_rdata_out <= {channel_overload_out,
          pump_battery_sel_out, hsr_trip, hsl_trip, ear_trip,
          hsr_powered, hsl_powered, ear_drv_on};
        `AODC_REG_HS_CUR_GAIN: reg_rdata_out <= {cur_right, cur_left};
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  assign ear_drv_on = earpiece_enable & ~ear_trip;
  assign ear_det = ear_short & ear_drv_on & ~earpiece_short_disable;
  assign hsl_det = hsl_short & hsl_powered & ~hs_short_disable;
  assign hsr_det = hsr_short & hsr_powered & ~hs_short_disable;
  assign det_vec = {hsr_det, hsl_det, ear_det};

  // set beats clear: a short in the clearing cycle stays visible
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_flags <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (det_vec[i]) begin
          irq_flags[i] <= 1'b1;
        end else if (rd_irq || (wr_irq && reg_wdata_in[i])) begin
          irq_flags[i] <= 1'b0;
        end
      end
    end
  end

  // trips release only once software drops the enable bit
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ear_trip <= 1'b0;
      hsl_trip <= 1'b0;
      hsr_trip <= 1'b0;
    end else begin
      if (auto_pd && ear_det) begin
        ear_trip <= 1'b1;
      end else if (!earpiece_enable) begin
        ear_trip <= 1'b0;
      end
      if (auto_pd && hsl_det) begin
        hsl_trip <= 1'b1;
      end else if (!(hs_follow_pump_enable ? neg_pump_enable : hs_en[0])) begin
        hsl_trip <= 1'b0;
      end
      if (auto_pd && hsr_det) begin
        hsr_trip <= 1'b1;
      end else if (!(hs_follow_pump_enable ? neg_pump_enable : hs_en[1])) begin
        hsr_trip <= 1'b0;
      end
    end
  end

  assign hsl_en_eff = (hs_follow_pump_enable ? neg_pump_enable : hs_en[0])
    & ~hsl_trip;
  assign hsr_en_eff = (hs_follow_pump_enable ? neg_pump_enable : hs_en[1])
    & ~hsr_trip;

  always_ff @(posedge core_clk_in) begin
    if (reset_in || div_cnt == 32'(STEP_BASE_CYCLES - 1)) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end
  assign step_tick = div_cnt == 32'(STEP_BASE_CYCLES - 1);

  aodc_hs_ramp u_ramp_left (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .enable_in(hsl_en_eff),
    .mute_in(hs_en[6]),
    .target_gain_in(hs_gain[3:0]),
    .step_tick_in(step_tick),
    .zero_cross_in(zc_left),
    .speed_in(hs_conf[1:0]),
    .ramp_disable_in(hs_conf[2]),
    .zc_disable_in(hs_conf[3]),
    .gain_out(cur_left),
    .powered_out(hsl_powered),
    .mute_out(hs_mute_left_out)
  );
  aodc_hs_ramp u_ramp_right (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .enable_in(hsr_en_eff),
    .mute_in(hs_en[7]),
    .target_gain_in(hs_gain[7:4]),
    .step_tick_in(step_tick),
    .zero_cross_in(zc_right),
    .speed_in(hs_conf[1:0]),
    .ramp_disable_in(hs_conf[2]),
    .zc_disable_in(hs_conf[3]),
    .gain_out(cur_right),
    .powered_out(hsr_powered),
    .mute_out(hs_mute_right_out)
  );
  aodc_env_det u_env (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .enable_in(pump_conf[2]),
    .manual_low_in(pump_conf[3]),
    .level_in(envelope_level_in),
    .high_thresh_in(env_thresh[3:0]),
    .low_thresh_in(env_thresh[7:4]),
    .decay_in(env_time),
    .tick_in(step_tick),
    .battery_sel_out(pump_battery_sel_out)
  );

  // line-out borrows these three DACs, so they count once here
  assign own_channels = {2'b00, ear_conf[1]} + {2'b00, hs_en[4]}
    + {2'b00, hs_en[5]};

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      bypass_gain_left_out <= 5'h00;
      bypass_gain_right_out <= 5'h00;
      hs_gain_db_left_out <= 8'sh00;
      hs_gain_db_right_out <= 8'sh00;
      channel_overload_out <= 1'b0;
    end else begin
      bypass_gain_left_out <= aodc_pkg::aodc_bypass_clamp(bypass_gain_left);
      bypass_gain_right_out <= aodc_pkg::aodc_bypass_clamp(bypass_gain_right);
      hs_gain_db_left_out <= aodc_pkg::aodc_hs_gain_db(cur_left);
      hs_gain_db_right_out <= aodc_pkg::aodc_hs_gain_db(cur_right);
      channel_overload_out <=
        ({1'b0, own_channels} + {1'b0, other_channels_in}) >
        {1'b0, `AODC_MAX_CHANNELS};
    end
  end

  // stage enables are passed through; bypass audio relies on them
  assign hs_stage_en_left_out = hs_en[2];
  assign hs_stage_en_right_out = hs_en[3];
  assign earpiece_drv_on_out = ear_drv_on;
  assign earpiece_dac_on_out = earpiece_dac_enable;
  assign earpiece_mute_out = ear_conf[2];
  assign earpiece_drv_lowpower_out = ear_conf[3];
  assign earpiece_dac_lowpower_out = ear_conf[4];
  assign earpiece_source_sel_out = ear_conf[5];
  assign earpiece_common_mode_sel_out = ear_conf[7:6];
  assign hs_gain_left_out = cur_left;
  assign hs_gain_right_out = cur_right;
  assign hs_drv_on_left_out = hsl_powered;
  assign hs_drv_on_right_out = hsr_powered;
  assign hs_dac_on_left_out = hs_en[4];
  assign hs_dac_on_right_out = hs_en[5];
  assign hs_highpass_enable_out = hs_conf[4];
  assign hs_drv_lowpower_out = hs_conf[5];
  assign hs_dac_lowpower_out = hs_conf[7:6];
  // pull-down only matters while both drivers are off; else hi-z
  assign hs_pulldown_out = short_conf[3] & ~hsl_powered & ~hsr_powered;
  assign neg_pump_run_out = neg_pump_enable;

  AST_EAR_FLAG: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ear_det |=> irq_flags[`AODC_IRQ_EAR])
    else $error("earpiece short not flagged");
  AST_HS_FLAG: assert property (@(posedge core_clk_in) disable iff (reset_in)
    hsl_det && !hsr_det |=> irq_flags[`AODC_IRQ_HSL])
    else $error("left headset short not flagged");
  sequence s_ear_short_auto;
    auto_pd && ear_det;
  endsequence
  AST_AUTO_PD: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_ear_short_auto |=> !earpiece_drv_on_out)
    else $error("earpiece not shut down on short");
  AST_NO_AUTO_PD: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !auto_pd && ear_drv_on && !reg_write_in |=> earpiece_drv_on_out)
    else $error("earpiece shut down without auto power-down");
  AST_EAR_DIS: assert property (@(posedge core_clk_in) disable iff (reset_in)
    earpiece_short_disable && ear_short |=> !($rose(irq_flags[0])))
    else $error("disabled earpiece detection raised a flag");
  AST_FLAG_STICKY: assert property (@(posedge core_clk_in) disable iff (reset_in)
    irq_flags[0] && !wr_irq && !rd_irq |=> irq_flags[0] [*1])
    else $error("short flag dropped without clear");
  AST_PULLDOWN: assert property (@(posedge core_clk_in) disable iff (reset_in)
    hsl_powered |-> !hs_pulldown_out)
    else $error("pull-down applied to a running headset");
  AST_READ_CLR: assert property (@(posedge core_clk_in) disable iff (reset_in)
    rd_irq && !ear_det |=> !irq_flags[0])
    else $error("read did not clear earpiece flag");
endmodule
`default_nettype wire

// ===== tb/test_aodc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "aodc_params.svh"
module test_aodc_top;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic ear_short_in = 1'b0;
  logic hs_short_left_in = 1'b0;
  logic hs_short_right_in = 1'b0;
  logic zero_cross_left_in = 1'b0;
  logic zero_cross_right_in = 1'b0;
  logic [3:0] envelope_level_in = 4'h0;
  logic [2:0] other_channels_in = 3'h0;
  logic [7:0] reg_rdata_out;
  logic [4:0] bypass_gain_left_out, bypass_gain_right_out;
  logic hs_stage_en_left_out, hs_stage_en_right_out, earpiece_drv_on_out;
  logic earpiece_dac_on_out, earpiece_mute_out, earpiece_drv_lowpower_out;
  logic earpiece_dac_lowpower_out, earpiece_source_sel_out;
  logic [1:0] earpiece_common_mode_sel_out, hs_dac_lowpower_out;
  logic [3:0] hs_gain_left_out, hs_gain_right_out;
  logic signed [7:0] hs_gain_db_left_out, hs_gain_db_right_out;
  logic hs_drv_on_left_out, hs_drv_on_right_out, hs_mute_left_out;
  logic hs_mute_right_out, hs_dac_on_left_out, hs_dac_on_right_out;
  logic hs_highpass_enable_out, hs_drv_lowpower_out, hs_pulldown_out;
  logic neg_pump_run_out, pump_battery_sel_out, channel_overload_out;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] rv;

  // short step base keeps ramp and decay waits to a few dozen cycles
  aodc_top #(.STEP_BASE_CYCLES(4)) i_aodc_top (.core_clk_in, .reset_in,
    .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
    .ear_short_in, .hs_short_left_in, .hs_short_right_in, .zero_cross_left_in,
    .zero_cross_right_in, .envelope_level_in, .other_channels_in,
    .bypass_gain_left_out, .bypass_gain_right_out, .hs_stage_en_left_out,
    .hs_stage_en_right_out, .earpiece_drv_on_out, .earpiece_dac_on_out,
    .earpiece_mute_out, .earpiece_drv_lowpower_out, .earpiece_dac_lowpower_out,
    .earpiece_source_sel_out, .earpiece_common_mode_sel_out, .hs_gain_left_out,
    .hs_gain_right_out, .hs_gain_db_left_out, .hs_gain_db_right_out,
    .hs_drv_on_left_out, .hs_drv_on_right_out, .hs_mute_left_out,
    .hs_mute_right_out, .hs_dac_on_left_out, .hs_dac_on_right_out,
    .hs_highpass_enable_out, .hs_drv_lowpower_out, .hs_dac_lowpower_out,
    .hs_pulldown_out, .neg_pump_run_out, .pump_battery_sel_out,
    .channel_overload_out);

  always #5 core_clk_in = ~core_clk_in;

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tk(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1;
    chk(nm, reg_rdata_out, exp);
  endtask

  task pulse_short(input int which);
    @(posedge core_clk_in);
    if (which == 0) ear_short_in <= 1'b1;
    else hs_short_left_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    ear_short_in <= 1'b0;
    hs_short_left_in <= 1'b0;
    tk(4);
  endtask

  initial begin
    repeat (10) @(posedge core_clk_in);
    reset_in <= 1'b0;
    tk(1);
    chk("mute", {hs_mute_left_out, hs_mute_right_out}, 2'h3);
    chk("batt_sel", pump_battery_sel_out, 1'b1);
    rd(`AODC_REG_SHORT_CONF, 8'h00, "short_conf");
    rd(`AODC_REG_IRQ, 8'h00, "irq_rst");
    wr(`AODC_REG_BYPASS_L, 8'h1F);
    wr(`AODC_REG_BYPASS_R, 8'h05);
    tk(1);
    chk("byp_l", bypass_gain_left_out, 5'h12);
    chk("byp_r", bypass_gain_right_out, 5'h05);
    wr(`AODC_REG_EAR_CONF, 8'hFF);
    chk("ear", {earpiece_drv_on_out, earpiece_dac_on_out, earpiece_mute_out,
      earpiece_drv_lowpower_out, earpiece_dac_lowpower_out}, 5'h1F);
    chk("ear_src", earpiece_source_sel_out, 1'b1);
    chk("ear_cm", earpiece_common_mode_sel_out, 2'h3);
    @(posedge core_clk_in);
    other_channels_in <= 3'h6;
    tk(3);
    chk("overload", channel_overload_out, 1'b1);
    @(posedge core_clk_in);
    other_channels_in <= 3'h0;
    wr(`AODC_REG_SHORT_CONF, 8'h01);
    pulse_short(0);
    chk("ear_trip", earpiece_drv_on_out, 1'b0);
    rd(`AODC_REG_IRQ, 8'h01, "irq_ear");
    rd(`AODC_REG_IRQ, 8'h00, "irq_clr");
    wr(`AODC_REG_EAR_CONF, 8'hFE);
    wr(`AODC_REG_EAR_CONF, 8'hFF);
    tk(1);
    chk("ear_restart", earpiece_drv_on_out, 1'b1);
    wr(`AODC_REG_SHORT_CONF, 8'h02);
    pulse_short(0);
    rd(`AODC_REG_IRQ, 8'h00, "ear_dis");
    wr(`AODC_REG_SHORT_CONF, 8'h00);
    wr(`AODC_REG_HS_CONF, 8'h08);
    wr(`AODC_REG_HS_GAIN, 8'h03);
    wr(`AODC_REG_HS_EN, 8'h05);
    tk(1);
    chk("hs_on", hs_drv_on_left_out, 1'b1);
    chk("stage", hs_stage_en_left_out, 1'b1);
    for (int i = 0; i < 200 && hs_gain_left_out !== 4'h3; i++) tk(1);
    tk(2);
    chk("ramp_up", {hs_mute_left_out, hs_gain_left_out}, 5'h03);
    chk("db_m20", {8'h00, hs_gain_db_left_out}, 16'h00EC);
    pulse_short(1);
    rd(`AODC_REG_IRQ, 8'h02, "irq_hsl");
    chk("no_pd", hs_drv_on_left_out, 1'b1);
    wr(`AODC_REG_HS_EN, 8'h41);
    chk("pre_mute", hs_mute_left_out, 1'b0);
    for (int i = 0; i < 200 && hs_mute_left_out !== 1'b1; i++) tk(1);
    chk("mute_gain", hs_gain_left_out, 4'h0);
    wr(`AODC_REG_HS_CONF, 8'h0C);
    wr(`AODC_REG_HS_EN, 8'h3F);
    wr(`AODC_REG_HS_GAIN, 8'h5F);
    tk(3);
    chk("no_ramp", {hs_gain_right_out, hs_gain_left_out}, 8'h5F);
    chk("db_p4", {hs_gain_db_right_out, hs_gain_db_left_out}, 16'hF004);
    chk("stage_r", hs_stage_en_right_out, 1'b1);
    chk("dac_on", {hs_dac_on_right_out, hs_dac_on_left_out}, 2'h3);
    wr(`AODC_REG_HS_CONF, 8'hF0);
    chk("hs_conf", {hs_dac_lowpower_out, hs_drv_lowpower_out,
      hs_highpass_enable_out}, 4'hF);
    wr(`AODC_REG_HS_EN, 8'h00);
    wr(`AODC_REG_SHORT_CONF, 8'h08);
    for (int i = 0; i < 200 && hs_drv_on_left_out !== 1'b0; i++) tk(1);
    tk(2);
    chk("pulldown", hs_pulldown_out, 1'b1);
    wr(`AODC_REG_PUMP_CONF, 8'h09);
    tk(2);
    chk("pump", {neg_pump_run_out, pump_battery_sel_out}, 2'h2);
    wr(`AODC_REG_PUMP_CONF, 8'h0B);
    tk(1);
    chk("follow", {hs_drv_on_left_out, hs_drv_on_right_out}, 2'h3);
    wr(`AODC_REG_ENV_THRESH, 8'h28);
    wr(`AODC_REG_ENV_TIME, 8'h04);
    wr(`AODC_REG_PUMP_CONF, 8'h05);
    @(posedge core_clk_in);
    envelope_level_in <= 4'h9;
    tk(2);
    chk("env_hi", pump_battery_sel_out, 1'b1);
    @(posedge core_clk_in);
    envelope_level_in <= 4'h0;
    tk(2);
    chk("env_hold", pump_battery_sel_out, 1'b1);
    for (int i = 0; i < 300 && pump_battery_sel_out !== 1'b0; i++) tk(1);
    chk("env_lo", pump_battery_sel_out, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
